// [rtl/dxra_defines.svh]
// Offsets, field positions, reset values and widths of the repeat window.
`ifndef DXRA_DEFINES_SVH
`define DXRA_DEFINES_SVH

`define DXRA_AW 32
`define DXRA_WIN_BITS_MAX 27
`define DXRA_NUM_EVT 3

`define DXRA_OFS_ADDR_CTRL 8'h00
`define DXRA_OFS_MODE 8'h04
`define DXRA_OFS_SRC_ADDR 8'h08
`define DXRA_OFS_DST_ADDR 8'h0C
`define DXRA_OFS_IRQ_STAT 8'h10
`define DXRA_OFS_IRQ_CLR 8'h14
`define DXRA_OFS_IRQ_EN 8'h18

`define DXRA_SRC_IE_BIT 15
`define DXRA_SRC_SIZE_HI 12
`define DXRA_SRC_SIZE_LO 8
`define DXRA_DST_IE_BIT 7
`define DXRA_DST_SIZE_HI 4
`define DXRA_DST_SIZE_LO 0
`define DXRA_CTRL_RW_MASK 32'h0000_9F9F

`define DXRA_MODE_TE_BIT 0
`define DXRA_MODE_FLAG_BIT 1

`define DXRA_EVT_SRC_OVF 0
`define DXRA_EVT_DST_OVF 1
`define DXRA_EVT_STOP 2

`define DXRA_RST_WORD 32'h0000_0000
`define DXRA_RST_SIZE 5'h00

`endif

// [rtl/dxra_pkg.sv]
// Types and the window mask decoder shared by the repeat window logic.
package dxra_pkg;

  typedef enum logic [1:0] {
    DXRA_FIXED = 2'b00,
    DXRA_OFFSET = 2'b01,
    DXRA_UP = 2'b10,
    DXRA_DOWN = 2'b11
  } dxra_upd_t;

  // Turns a window size code into a mask of the lower address bits.
  function automatic logic [31:0] dxra_win_mask(input logic [4:0] bits);
    logic [31:0] m;
    m = 32'h0000_0000;
    for (int i = 0; i < 32; i++) begin
      if (i < int'(bits)) begin
        m[i] = 1'b1;
      end
    end
    return m;
  endfunction : dxra_win_mask

endpackage : dxra_pkg

// [rtl/dxra_addr_wrap.sv]
// Next-address computation confined to a power-of-two repeat window.
`timescale 1ns/1ns
`include "dxra_defines.svh"
module dxra_addr_wrap
  import dxra_pkg::*;
#(
  parameter int MAX_BITS = `DXRA_WIN_BITS_MAX
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [31:0] addr_i,
  input wire logic [4:0] size_i,
  input wire dxra_upd_t mode_i,
  input wire logic [31:0] delta_i,
  output logic [31:0] next_o,
  output logic ovf_o
);

  localparam logic [4:0] MaxBits = MAX_BITS[4:0];

  wire [4:0] bits = (size_i > MaxBits) ? MaxBits : size_i; // RQ9
  wire [31:0] mask = dxra_win_mask(bits); // RQ13
  wire windowed = (size_i != `DXRA_RST_SIZE);
  wire up = (mode_i == DXRA_UP) || (mode_i == DXRA_OFFSET);
  wire down = (mode_i == DXRA_DOWN);
  wire [31:0] low = addr_i & mask;
  wire [32:0] low_sum = {1'b0, low} + {1'b0, delta_i};
  wire ovf_up = up && (low_sum > {1'b0, mask}); // RQ15
  wire ovf_dn = down && (low < delta_i); // RQ15
  wire [31:0] raw = up ? addr_i + delta_i :
                    down ? addr_i - delta_i : addr_i;

  // Upper bits stay put; an overflow reloads the window start or end.
  assign next_o = !windowed ? raw :
                  ovf_up ? (addr_i & ~mask) : // RQ10
                  ovf_dn ? (addr_i | mask) :  // RQ10
                  ((addr_i & ~mask) | (raw & mask)); // RQ8
  assign ovf_o = windowed && (ovf_up || ovf_dn);

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  upper_fixed_a: assert property ( // RQ8
    windowed |-> (((next_o ^ addr_i) & ~mask) == 32'h0000_0000))
    else $error("upper address bits moved inside a window");
  wrap_start_a: assert property ( // RQ10
    (windowed && ovf_up) |-> ((next_o & mask) == 32'h0000_0000))
    else $error("incrementing overflow did not reload window start");
  wrap_end_a: assert property ( // RQ10
    (windowed && ovf_dn) |-> ((next_o & mask) == mask))
    else $error("decrementing overflow did not reload window end");

endmodule : dxra_addr_wrap

// [rtl/dxra_irq.sv]
// Sticky event status, enable mask and level interrupt output.
`timescale 1ns/1ns
module dxra_irq #(
  parameter int N = 3
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [N-1:0] set_i,
  input wire logic clr_we_i,
  input wire logic [N-1:0] clr_i,
  input wire logic en_we_i,
  input wire logic [N-1:0] en_i,
  output logic [N-1:0] status_o,
  output logic [N-1:0] en_o,
  output logic irq_o
);

  logic [N-1:0] status_r;
  logic [N-1:0] en_r;

  // A set in the same cycle as a clear wins.
  wire [N-1:0] status_nxt = (status_r & ~(clr_we_i ? clr_i : '0)) | set_i;
  wire [N-1:0] en_nxt = en_we_i ? en_i : en_r;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      status_r <= '0;
      en_r <= '0;
    end else begin
      status_r <= status_nxt;
      en_r <= en_nxt;
    end
  end

  assign status_o = status_r;
  assign en_o = en_r;
  assign irq_o = |(status_r & en_r);

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  set_wins_a: assert property (set_i[0] |=> status_o[0])
    else $error("event lost against a status clear");
  irq_level_a: assert property (
    (set_i[0] && en_r[0] && !en_we_i) |=> irq_o)
    else $error("enabled event did not raise the interrupt");

endmodule : dxra_irq

// [rtl/dxra_top.sv]
// Extended repeat window unit of one DMA channel with a Wishbone slave.
//
// Operation
// RQ1 - Enabled source window overflow clears the channel transfer enable.
// RQ2 - A stop by enabled window overflow sets the extended area flag.
// RQ3 - Enabled destination window overflow also stops channel and sets flag.
// RQ4 - In block mode the overflow stop waits until the block ends.
// RQ5 - Setting transfer enable again resumes from the stopped addresses.
// RQ6 - Overflow enables are ignored when that side has no window.
// RQ7 - Control bits 14 and 13 read zero and ignore writes.
// RQ8 - Source window size at bits 12..8; only lower bits move.
// RQ9 - Windows are powers of two up to 128 Mbytes.
// RQ10 - Overflow reloads window start on increment, end on decrement.
// RQ11 - Source enable at bit 15, destination enable at bit 7, reset zero.
// RQ12 - Each enable gates its own side's overflow stop request.
// RQ13 - Size code zero means no window; code n means 2^n bytes.
// RQ14 - Destination window size at bits 4..0, same behaviour as source.
// RQ15 - Overflow is carry or borrow out of the masked lower bits.
`timescale 1ns/1ns
`include "dxra_defines.svh"
module dxra_top
  import dxra_pkg::*;
#(
  parameter int MAX_BITS = `DXRA_WIN_BITS_MAX
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic step_i,
  input wire dxra_upd_t src_mode_i,
  input wire dxra_upd_t dst_mode_i,
  input wire logic [31:0] src_delta_i,
  input wire logic [31:0] dst_delta_i,
  input wire logic block_mode_i,
  input wire logic block_end_i,
  output logic channel_transfer_enable_o,
  output logic extended_area_irq_flag_o,
  output logic [31:0] src_addr_o,
  output logic [31:0] dst_addr_o,
  output logic irq_o
);

  // ----------------------------------------------------------------
  // Byte-lane merge
  // ----------------------------------------------------------------
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] dat,
                                        input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        r[8*b +: 8] = dat[8*b +: 8];
      end
    end
    return r;
  endfunction : merge

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [31:0] ctrl_r;
  logic [31:0] src_addr_r;
  logic [31:0] dst_addr_r;
  logic te_r;
  logic flag_r;
  logic src_pend_r;
  logic dst_pend_r;
  logic ack_r;
  logic [31:0] dat_r;

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  wire req = wb_cyc_i && wb_stb_i;
  wire wr = ack_r && req && wb_we_i;
  wire wr_ctrl = wr && (wb_adr_i == `DXRA_OFS_ADDR_CTRL);
  wire wr_mode = wr && (wb_adr_i == `DXRA_OFS_MODE);
  wire wr_src = wr && (wb_adr_i == `DXRA_OFS_SRC_ADDR);
  wire wr_dst = wr && (wb_adr_i == `DXRA_OFS_DST_ADDR);
  wire wr_clr = wr && (wb_adr_i == `DXRA_OFS_IRQ_CLR);
  wire wr_en = wr && (wb_adr_i == `DXRA_OFS_IRQ_EN);

  wire src_ie = ctrl_r[`DXRA_SRC_IE_BIT]; // RQ11
  wire dst_ie = ctrl_r[`DXRA_DST_IE_BIT]; // RQ11
  wire [4:0] src_size = ctrl_r[`DXRA_SRC_SIZE_HI:`DXRA_SRC_SIZE_LO]; // RQ8
  wire [4:0] dst_size = ctrl_r[`DXRA_DST_SIZE_HI:`DXRA_DST_SIZE_LO]; // RQ14

  // ----------------------------------------------------------------
  // Address update
  // ----------------------------------------------------------------
  logic [31:0] src_next;
  logic [31:0] dst_next;
  logic src_ovf;
  logic dst_ovf;

  dxra_addr_wrap #(.MAX_BITS(MAX_BITS)) u_src_wrap (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .addr_i(src_addr_r),
    .size_i(src_size),
    .mode_i(src_mode_i),
    .delta_i(src_delta_i),
    .next_o(src_next),
    .ovf_o(src_ovf)
  );

  dxra_addr_wrap #(.MAX_BITS(MAX_BITS)) u_dst_wrap (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .addr_i(dst_addr_r),
    .size_i(dst_size),
    .mode_i(dst_mode_i),
    .delta_i(dst_delta_i),
    .next_o(dst_next),
    .ovf_o(dst_ovf)
  );

  // ----------------------------------------------------------------
  // Overflow stop
  // ----------------------------------------------------------------
  wire go = step_i && te_r;
  // The wrap unit reports overflow only with a window set.
  wire src_hit = go && src_ovf && src_ie; // RQ1 RQ6 RQ12
  wire dst_hit = go && dst_ovf && dst_ie; // RQ3 RQ6 RQ12
  wire any_hit = src_hit || dst_hit || src_pend_r || dst_pend_r;
  // Block mode holds the request until the block is done.
  wire stop = go && any_hit && (!block_mode_i || block_end_i); // RQ4
  wire src_pend_nxt = stop ? 1'b0 : (src_pend_r || src_hit); // RQ4
  wire dst_pend_nxt = stop ? 1'b0 : (dst_pend_r || dst_hit); // RQ4

  // Software may set the enable; a hardware stop in the same cycle wins.
  wire te_wr = wr_mode && wb_sel_i[0];
  wire te_nxt = stop ? 1'b0 : // RQ1 RQ3
                te_wr ? wb_dat_i[`DXRA_MODE_TE_BIT] : te_r; // RQ5
  wire flag_nxt = stop ? 1'b1 : // RQ2 RQ3
                  te_wr ? (flag_r & wb_dat_i[`DXRA_MODE_FLAG_BIT]) : flag_r;

  // Addresses only move on an accepted step or a bus write, so a stop freezes them.
  wire [31:0] src_addr_nxt = wr_src ? merge(src_addr_r, wb_dat_i, wb_sel_i) :
                             go ? src_next : src_addr_r; // RQ5
  wire [31:0] dst_addr_nxt = wr_dst ? merge(dst_addr_r, wb_dat_i, wb_sel_i) :
                             go ? dst_next : dst_addr_r; // RQ5
  wire [31:0] ctrl_nxt = wr_ctrl ?
    (merge(ctrl_r, wb_dat_i, wb_sel_i) & `DXRA_CTRL_RW_MASK) : ctrl_r; // RQ7

  // ----------------------------------------------------------------
  // Interrupt status
  // ----------------------------------------------------------------
  logic [`DXRA_NUM_EVT-1:0] irq_stat;
  logic [`DXRA_NUM_EVT-1:0] irq_en;
  wire [`DXRA_NUM_EVT-1:0] evt = {stop, go && dst_ovf, go && src_ovf};

  dxra_irq #(.N(`DXRA_NUM_EVT)) u_irq (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .set_i(evt),
    .clr_we_i(wr_clr),
    .clr_i(wb_dat_i[`DXRA_NUM_EVT-1:0]),
    .en_we_i(wr_en),
    .en_i(wb_dat_i[`DXRA_NUM_EVT-1:0]),
    .status_o(irq_stat),
    .en_o(irq_en),
    .irq_o(irq_o)
  );

  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------
  wire [31:0] mode_word = {30'h0000_0000, flag_r, te_r};
  wire [31:0] rd_mux =
    (wb_adr_i == `DXRA_OFS_ADDR_CTRL) ? ctrl_r : // RQ7
    (wb_adr_i == `DXRA_OFS_MODE) ? mode_word :
    (wb_adr_i == `DXRA_OFS_SRC_ADDR) ? src_addr_r :
    (wb_adr_i == `DXRA_OFS_DST_ADDR) ? dst_addr_r :
    (wb_adr_i == `DXRA_OFS_IRQ_STAT) ? {29'h0000_0000, irq_stat} :
    (wb_adr_i == `DXRA_OFS_IRQ_EN) ? {29'h0000_0000, irq_en} :
    `DXRA_RST_WORD;
  wire ack_nxt = req && !ack_r;
  wire [31:0] dat_nxt = ack_nxt ? rd_mux : dat_r;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_r <= 1'b0;
      dat_r <= `DXRA_RST_WORD;
    end else begin
      ack_r <= ack_nxt;
      dat_r <= dat_nxt;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_r <= `DXRA_RST_WORD;
      src_addr_r <= `DXRA_RST_WORD;
      dst_addr_r <= `DXRA_RST_WORD;
      te_r <= 1'b0;
      flag_r <= 1'b0;
      src_pend_r <= 1'b0;
      dst_pend_r <= 1'b0;
    end else begin
      ctrl_r <= ctrl_nxt;
      src_addr_r <= src_addr_nxt;
      dst_addr_r <= dst_addr_nxt;
      te_r <= te_nxt;
      flag_r <= flag_nxt;
      src_pend_r <= src_pend_nxt;
      dst_pend_r <= dst_pend_nxt;
    end
  end

  assign wb_ack_o = ack_r;
  assign wb_dat_o = dat_r;
  assign channel_transfer_enable_o = te_r;
  assign extended_area_irq_flag_o = flag_r;
  assign src_addr_o = src_addr_r;
  assign dst_addr_o = dst_addr_r;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  src_stop_a: assert property ( // RQ1
    (go && src_ovf && src_ie && !block_mode_i) |=> (!te_r && flag_r))
    else $error("source overflow did not stop the channel");
  stop_flag_a: assert property ( // RQ2
    $fell(te_r) && !$past(te_wr) |-> flag_r)
    else $error("overflow stop left the flag clear");
  dst_stop_a: assert property ( // RQ3
    (go && dst_ovf && dst_ie && !block_mode_i) |=> (!te_r && flag_r))
    else $error("destination overflow did not stop the channel");
  block_defer_a: assert property ( // RQ4
    (go && block_mode_i && !block_end_i && !te_wr) |=> te_r)
    else $error("block transfer stopped before its end");
  resume_addr_a: assert property ( // RQ5
    (!te_r && !wr_src) |=> (src_addr_r == $past(src_addr_r)))
    else $error("source address moved while stopped");
  no_window_a: assert property ( // RQ6
    (go && src_size == 5'h00 && dst_size == 5'h00 && !src_pend_r
     && !dst_pend_r && !te_wr) |=> te_r)
    else $error("channel stopped with no window set");
  rsvd_read_a: assert property ( // RQ7
    (wb_ack_o && !wb_we_i && $past(wb_adr_i) == `DXRA_OFS_ADDR_CTRL)
    |-> (wb_dat_o[14:13] == 2'b00))
    else $error("reserved control bits read nonzero");
  ie_read_a: assert property ( // RQ11
    (ack_nxt && !wb_we_i && wb_adr_i == `DXRA_OFS_ADDR_CTRL)
    |=> (wb_dat_o[15] == $past(src_ie) && wb_dat_o[7] == $past(dst_ie)))
    else $error("overflow enables read back wrong");
  ack_once_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("acknowledge held for two cycles");

  // ----------------------------------------------------------------
  // Register and window checks
  // ----------------------------------------------------------------
  // A side whose enable is clear must not stop the channel by itself.
  src_ie_gate_a: assert property ( // RQ12
    (go && src_ovf && !src_ie && !dst_hit && !src_pend_r && !dst_pend_r
     && !te_wr) |=> te_r)
    else $error("disabled source overflow stopped the channel");
  dst_ie_gate_a: assert property ( // RQ12
    (go && dst_ovf && !dst_ie && !src_hit && !src_pend_r && !dst_pend_r
     && !te_wr) |=> te_r)
    else $error("disabled destination overflow stopped the channel");
  pend_hold_a: assert property ( // RQ4
    ((src_hit || dst_hit) && block_mode_i && !block_end_i)
    |=> (src_pend_r || dst_pend_r))
    else $error("overflow inside a block was not held pending");
  block_stop_a: assert property ( // RQ4
    (go && block_mode_i && block_end_i && (src_pend_r || dst_pend_r))
    |=> (!te_r && flag_r))
    else $error("pending overflow did not stop at block end");
  flag_hold_a: assert property ( // RQ2
    (flag_r && !te_wr) |=> flag_r)
    else $error("extended area flag cleared without a mode write");
  dst_frozen_a: assert property ( // RQ5
    (!te_r && !wr_dst) |=> (dst_addr_r == $past(dst_addr_r)))
    else $error("destination address moved while stopped");
  ie_write_a: assert property ( // RQ11
    (wr_ctrl && wb_sel_i[1] && wb_sel_i[0])
    |=> (src_ie == $past(wb_dat_i[`DXRA_SRC_IE_BIT])
         && dst_ie == $past(wb_dat_i[`DXRA_DST_IE_BIT])))
    else $error("overflow enable write did not land");
  size_write_a: assert property ( // RQ8 RQ14
    (wr_ctrl && wb_sel_i[1] && wb_sel_i[0])
    |=> (src_size == $past(wb_dat_i[`DXRA_SRC_SIZE_HI:`DXRA_SRC_SIZE_LO])
         && dst_size == $past(wb_dat_i[`DXRA_DST_SIZE_HI:`DXRA_DST_SIZE_LO])))
    else $error("window size write did not land");
  rsvd_zero_a: assert property ( // RQ7
    ctrl_r[`DXRA_SRC_IE_BIT-1:`DXRA_SRC_SIZE_HI+1] == 2'b00)
    else $error("reserved control bits hold a one");
  win_limit_a: assert property ( // RQ9
    (src_size != `DXRA_RST_SIZE)
    |-> (((src_next ^ src_addr_r) & ~dxra_win_mask(MAX_BITS[4:0]))
         == 32'h0000_0000))
    else $error("source window reached past its largest size");
  no_window_ovf_a: assert property ( // RQ13
    ((src_size == `DXRA_RST_SIZE) |-> !src_ovf)
    and ((dst_size == `DXRA_RST_SIZE) |-> !dst_ovf))
    else $error("overflow reported with no window set");

endmodule : dxra_top

// [sim/dxra_xfer_model.sv]
// Transfer side model that reports finished transfers as step pulses.
`timescale 1ns/1ns
module dxra_xfer_model (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic go_i,
  input wire logic [7:0] n_i,
  input wire logic slow_i,
  input wire logic blk_i,
  output logic step_o,
  output logic blk_end_o,
  output logic busy_o
);
  logic [7:0] left_r;
  logic gap_r;

  // Slow mode leaves an idle cycle between transfers.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      left_r <= 8'h00;
      gap_r <= 1'b0;
      step_o <= 1'b0;
      blk_end_o <= 1'b0;
    end else if (go_i && left_r == 8'h00) begin
      left_r <= n_i;
      gap_r <= 1'b0;
      step_o <= 1'b0;
      blk_end_o <= 1'b0;
    end else if (left_r != 8'h00 && !gap_r) begin
      step_o <= 1'b1;
      blk_end_o <= blk_i && left_r == 8'h01;
      left_r <= left_r - 8'h01;
      gap_r <= slow_i;
    end else begin
      step_o <= 1'b0;
      blk_end_o <= 1'b0;
      gap_r <= 1'b0;
    end
  end

  assign busy_o = (left_r != 8'h00) || step_o;
endmodule : dxra_xfer_model

// [sim/tb_top.sv]
// Self-checking bench of the repeat window unit.
`timescale 1ns/1ns
module tb_top
  import dxra_pkg::*;
;
  typedef struct packed {
    logic side;
    logic [4:0] code;
    logic ie;
    dxra_upd_t mode;
    logic [31:0] delta;
    logic [31:0] addr;
    logic [31:0] exp;
    logic ovf;
    logic te;
  } dxra_row_t;

  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h0000_0000;
  logic [3:0] sel = 4'h0;
  logic [31:0] rdata;
  logic [31:0] wb_dat_o, src_addr_o, dst_addr_o;
  logic wb_ack_o, te_o, flag_o, irq_o, step, blk_end, busy;
  dxra_upd_t src_mode = DXRA_FIXED;
  dxra_upd_t dst_mode = DXRA_FIXED;
  logic [31:0] src_delta = 32'h0000_0000;
  logic [31:0] dst_delta = 32'h0000_0000;
  logic blk_mode = 1'b0;
  logic go = 1'b0;
  logic slow = 1'b0;
  logic blk = 1'b0;
  logic [7:0] n_steps = 8'h00;
  int num_errors = 0;
  int n_compared = 0;
  dxra_row_t rows [8] = '{
    '{1'b0, 5'h02, 1'b1, DXRA_UP, 32'h0000_0001, 32'h1234_5673,
      32'h1234_5670, 1'b1, 1'b0},
    '{1'b0, 5'h02, 1'b0, DXRA_DOWN, 32'h0000_0001, 32'h1234_5670,
      32'h1234_5673, 1'b1, 1'b1},
    '{1'b0, 5'h00, 1'b1, DXRA_UP, 32'h0000_0004, 32'h0000_00FC,
      32'h0000_0100, 1'b0, 1'b1},
    '{1'b0, 5'h08, 1'b1, DXRA_UP, 32'h0000_0001, 32'hABCD_12FE,
      32'hABCD_12FF, 1'b0, 1'b1},
    '{1'b0, 5'h1B, 1'b1, DXRA_UP, 32'h0000_0004, 32'h17FF_FFFC,
      32'h1000_0000, 1'b1, 1'b0},
    '{1'b1, 5'h03, 1'b1, DXRA_DOWN, 32'h0000_0002, 32'h0000_0041,
      32'h0000_0047, 1'b1, 1'b0},
    '{1'b1, 5'h01, 1'b0, DXRA_OFFSET, 32'h0000_0002, 32'h0000_0010,
      32'h0000_0010, 1'b1, 1'b1},
    '{1'b1, 5'h04, 1'b1, DXRA_FIXED, 32'h0000_0004, 32'h0000_0033,
      32'h0000_0033, 1'b0, 1'b1}
  };

  always #50 clk_i = ~clk_i;

  dxra_top i_dxra_top (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .step_i(step),
    .src_mode_i(src_mode), .dst_mode_i(dst_mode),
    .src_delta_i(src_delta), .dst_delta_i(dst_delta),
    .block_mode_i(blk_mode), .block_end_i(blk_end),
    .channel_transfer_enable_o(te_o), .extended_area_irq_flag_o(flag_o),
    .src_addr_o(src_addr_o), .dst_addr_o(dst_addr_o), .irq_o(irq_o)
  );

  dxra_xfer_model i_dxra_xfer_model (
    .clk_i(clk_i), .rst_i(rst_i), .go_i(go), .n_i(n_steps),
    .slow_i(slow), .blk_i(blk), .step_o(step), .blk_end_o(blk_end),
    .busy_o(busy)
  );

  // ---------------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic wb(input logic w, input logic [7:0] a,
                    input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    sel <= 4'hF;
    adr <= a;
    wdat <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    if (n >= 20) begin
      num_errors++;
      $display("Error at %0t: no bus answer", $time);
    end
    rdata = wb_dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    sel <= 4'h0;
  endtask : wb

  task automatic run(input logic [7:0] n, input logic s, input logic b);
    @(posedge clk_i);
    n_steps <= n;
    slow <= s;
    blk <= b;
    go <= 1'b1;
    @(posedge clk_i);
    go <= 1'b0;
    for (int k = 0; k < 40; k++) begin
      @(posedge clk_i);
      #1;
      if (busy !== 1'b1) break;
    end
  endtask : run

  task automatic summarize;
    $display("compared %0d mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : summarize

  // ---------------------------------------------------------------------
  // Tests
  // ---------------------------------------------------------------------
  initial begin
    #500000;
    num_errors++;
    summarize();
  end

  initial begin
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    #1;
    chk({29'h0000_0000, te_o, flag_o, irq_o}, 32'h0000_0000);
    wb(1'b0, 8'h00, 32'h0000_0000);
    chk(rdata, 32'h0000_0000);
    $display("test reset done");
    foreach (rows[i]) begin
      wb(1'b1, 8'h04, 32'h0000_0000);
      wb(1'b1, 8'h00, rows[i].side ?
         {24'h00_0000, rows[i].ie, 2'b00, rows[i].code} :
         {16'h0000, rows[i].ie, 2'b00, rows[i].code, 8'h00});
      wb(1'b1, rows[i].side ? 8'h0C : 8'h08, rows[i].addr);
      wb(1'b1, 8'h14, 32'h0000_0007);
      src_mode <= rows[i].side ? DXRA_FIXED : rows[i].mode;
      dst_mode <= rows[i].side ? rows[i].mode : DXRA_FIXED;
      src_delta <= rows[i].delta;
      dst_delta <= rows[i].delta;
      wb(1'b1, 8'h04, 32'h0000_0001);
      run(8'h01, 1'b0, 1'b0);
      chk(rows[i].side ? dst_addr_o : src_addr_o, rows[i].exp);
      chk({30'h0000_0000, te_o, flag_o}, {30'h0000_0000, rows[i].te,
          ~rows[i].te});
      wb(1'b0, 8'h10, 32'h0000_0000);
      chk(rdata, {29'h0000_0000, ~rows[i].te, rows[i].side & rows[i].ovf,
          ~rows[i].side & rows[i].ovf});
    end
    $display("test rows done");
    wb(1'b1, 8'h00, 32'hFFFF_FFFF);
    wb(1'b0, 8'h00, 32'h0000_0000);
    chk(rdata, 32'h0000_9F9F);
    wb(1'b0, 8'h1C, 32'h0000_0000);
    chk(rdata, 32'h0000_0000);
    $display("test reserved done");
    wb(1'b1, 8'h04, 32'h0000_0000);
    wb(1'b1, 8'h00, 32'h0000_8200);
    wb(1'b1, 8'h08, 32'h1234_5673);
    wb(1'b1, 8'h14, 32'h0000_0007);
    src_mode <= DXRA_UP;
    dst_mode <= DXRA_FIXED;
    src_delta <= 32'h0000_0001;
    blk_mode <= 1'b1;
    wb(1'b1, 8'h04, 32'h0000_0001);
    run(8'h01, 1'b0, 1'b0);
    chk({31'h0000_0000, te_o}, 32'h0000_0001);
    run(8'h02, 1'b1, 1'b1);
    chk({30'h0000_0000, te_o, flag_o}, 32'h0000_0001);
    run(8'h01, 1'b0, 1'b0);
    chk(src_addr_o, 32'h1234_5672);
    wb(1'b1, 8'h04, 32'h0000_0001);
    run(8'h01, 1'b0, 1'b0);
    chk({te_o, src_addr_o[30:0]}, 32'h9234_5673);
    $display("test block done");
    wb(1'b0, 8'h10, 32'h0000_0000);
    chk(rdata, 32'h0000_0005);
    wb(1'b1, 8'h18, 32'h0000_0004);
    repeat (2) @(posedge clk_i);
    #1;
    chk({31'h0000_0000, irq_o}, 32'h0000_0001);
    wb(1'b1, 8'h18, 32'h0000_0001);
    wb(1'b1, 8'h14, 32'h0000_0001);
    repeat (2) @(posedge clk_i);
    #1;
    chk({31'h0000_0000, irq_o}, 32'h0000_0000);
    wb(1'b0, 8'h10, 32'h0000_0000);
    chk(rdata, 32'h0000_0004);
    $display("test irq done");
    summarize();
  end
endmodule : tb_top
